// [verilog/prs_defs.svh]
// Constants for the power role swap policy engine
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH
`define PRS_MSG_W           3
`define PRS_MSG_NONE        3'h0
`define PRS_MSG_ACCEPT      3'h1
`define PRS_MSG_REJECT      3'h2
`define PRS_MSG_WAIT        3'h3
`define PRS_MSG_PR_SWAP     3'h4
`define PRS_MSG_PS_RDY      3'h5
`define PRS_MSG_GET_SRC_CAP 3'h6
`define PRS_MSG_SRC_CAPS    3'h7
`define PRS_TMR_W           20
`define PRS_SENDER_RESP_CYC 20'h00400
`define PRS_SRC_OFF_CYC     20'h01000
`define PRS_SRC_ACT_CYC     20'h01000
`define PRS_DEV_PROVIDER    2'h0
`define PRS_DEV_PROV_CONS   2'h1
`define PRS_DEV_CONS_PROV   2'h2
`endif

// [verilog/prs_pkg.sv]
// Types for the power role swap policy engine
package prs_pkg;
   typedef enum logic [3:0] {
      PRS_SINK_READY      = 4'h0,
      PRS_SNK_JUDGE       = 4'h1,
      PRS_SNK_AGREE       = 4'h3,
      PRS_SNK_POWER_DOWN  = 4'h2,
      PRS_PULLUP_ASSERT   = 4'h6,
      PRS_SUPPLY_ENABLE   = 4'h7,
      PRS_SOURCE_STARTUP  = 4'h5,
      PRS_SOURCE_READY    = 4'h4,
      PRS_SNK_REQUEST     = 4'hc,
      PRS_SNK_REFUSE      = 4'hd,
      PRS_SRC_REQUEST     = 4'hf,
      PRS_SRC_POWER_DOWN  = 4'he,
      PRS_SRC_REFUSE      = 4'ha,
      PRS_FETCH_CAPS      = 4'hb,
      PRS_SRC_HARD_RESET  = 4'h9,
      PRS_SNK_HARD_RESET  = 4'h8
   } prs_state_t;
endpackage : prs_pkg

// [verilog/prs_tmr_if.sv]
// Timer control bundle between the engine and its timers
`timescale 1ns/1ns
`default_nettype none
interface prs_tmr_if;
   logic start;
   logic stop;
   logic expired;
   modport ctl (output start, output stop, input expired);
   modport tmr (input start, input stop, output expired);
endinterface : prs_tmr_if
`default_nettype wire

// [verilog/prs_timer.sv]
// One-shot expiry timer counted in clock cycles
`timescale 1ns/1ns
`default_nettype none
`include "prs_defs.svh"
module prs_timer #(
   parameter logic [`PRS_TMR_W-1:0] CYCLES = `PRS_SENDER_RESP_CYC
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic ce,
   prs_tmr_if.tmr    t
);
   logic [`PRS_TMR_W-1:0] cnt_r;
   logic [`PRS_TMR_W-1:0] cnt_nxt;
   logic                  run_r;
   logic                  run_nxt;
   logic                  exp_r;
   logic                  exp_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      exp_nxt = 1'b0;
      // Stop wins over start so a state left in its entry cycle leaves no timer running, except the off timer when hard reset ends PRS_SNK_POWER_DOWN
      if (t.stop) begin
         run_nxt = 1'b0;
      end else if (t.start) begin
         cnt_nxt = CYCLES;
         run_nxt = 1'b1;
      end else if (run_r) begin
         if (cnt_r <= `PRS_TMR_W'(1)) begin
            run_nxt = 1'b0;
            exp_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - `PRS_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign t.expired = exp_r;

   // Expiry only after a run was started and not stopped
   a_tmr_no_idle_exp: assert property (@(posedge clk) disable iff (!resetn)
      (ce && !run_r) |=> !exp_r) else $error("timer expired while idle");
endmodule : prs_timer
`default_nettype wire

// [verilog/prs_policy_engine.sv]
// Power role swap policy engine for a dual-role port
`timescale 1ns/1ns
`default_nettype none
`include "prs_defs.svh"

module prs_policy_engine
   import prs_pkg::*;
#(
   parameter logic [`PRS_TMR_W-1:0] SENDER_RESP_CYC = `PRS_SENDER_RESP_CYC,
   parameter logic [`PRS_TMR_W-1:0] SRC_OFF_CYC     = `PRS_SRC_OFF_CYC,
   parameter logic [`PRS_TMR_W-1:0] SRC_ACT_CYC     = `PRS_SRC_ACT_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   input  wire logic                  start_as_source,
   input  wire logic                  toggling_dual_role_port,
   input  wire logic [1:0]            device_type,
   input  wire logic                  hard_reset,
   input  wire logic                  dpm_swap_required,
   input  wire logic                  dpm_get_caps,
   input  wire logic                  dpm_eval_valid,
   input  wire logic                  dpm_eval_ok,
   input  wire logic                  dpm_eval_wait,
   input  wire logic                  dpm_pullup_done,
   input  wire logic                  dpm_source_on,
   output logic                       dpm_eval_req,
   output logic                       dpm_sink_off_req,
   output logic                       dpm_pullup_req,
   output logic                       dpm_source_on_req,
   output logic                       dpm_caps_done,
   output logic                       dpm_caps_timeout,
   output logic                       error_recovery_state,
   output logic [3:0]                 state_out,
   input  wire logic                  rx_valid,
   input  wire logic [`PRS_MSG_W-1:0] rx_msg,
   output logic                       tx_req,
   output logic [`PRS_MSG_W-1:0]      tx_msg,
   input  wire logic                  tx_sent,
   input  wire logic                  tx_failed,
   output logic                       act_timer_expired
);
   // ---------------------------------------------------------------
   // Timers
   // ---------------------------------------------------------------
   prs_tmr_if resp_t ();
   prs_tmr_if off_t ();
   prs_tmr_if act_t ();

   prs_timer #(.CYCLES(SENDER_RESP_CYC)) u_resp (
      .clk(clk), .resetn(resetn), .ce(ce), .t(resp_t.tmr));
   prs_timer #(.CYCLES(SRC_OFF_CYC)) u_off (
      .clk(clk), .resetn(resetn), .ce(ce), .t(off_t.tmr));
   prs_timer #(.CYCLES(SRC_ACT_CYC)) u_act (
      .clk(clk), .resetn(resetn), .ce(ce), .t(act_t.tmr));

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   prs_state_t              state_r;
   prs_state_t              state_nxt;
   logic                    entry_r;
   logic                    entry_nxt;
   logic                    refuse_wait_r;
   logic                    refuse_wait_nxt;
   logic                    tx_req_r;
   logic                    tx_req_nxt;
   logic [`PRS_MSG_W-1:0]   tx_msg_r;
   logic [`PRS_MSG_W-1:0]   tx_msg_nxt;
   logic                    caps_done_r;
   logic                    caps_done_nxt;
   logic                    caps_to_r;
   logic                    caps_to_nxt;

   function automatic logic got(input logic v, input logic [`PRS_MSG_W-1:0] m,
                                input logic [`PRS_MSG_W-1:0] want);
      got = v && (m == want);
   endfunction : got

   // hard reset target by device type
   function automatic prs_state_t hr_target(input logic [1:0] dt);
      hr_target = (dt == `PRS_DEV_CONS_PROV) ? PRS_SNK_HARD_RESET : PRS_SRC_HARD_RESET;
   endfunction : hr_target

   function automatic prs_state_t fail_target(input logic tog, input logic [1:0] dt);
      fail_target = tog ? PRS_SNK_HARD_RESET : hr_target(dt);
   endfunction : fail_target

   logic rx_accept;
   logic rx_reject;
   logic rx_wait;
   assign rx_accept = got(rx_valid, rx_msg, `PRS_MSG_ACCEPT);
   assign rx_reject = got(rx_valid, rx_msg, `PRS_MSG_REJECT);
   assign rx_wait   = got(rx_valid, rx_msg, `PRS_MSG_WAIT);

   logic err_rec_nxt;
   logic err_rec_r;

   always_comb begin
      state_nxt       = state_r;
      entry_nxt       = 1'b0;
      refuse_wait_nxt = refuse_wait_r;
      tx_req_nxt      = 1'b0;
      tx_msg_nxt      = tx_msg_r;
      caps_done_nxt   = 1'b0;
      caps_to_nxt     = 1'b0;
      err_rec_nxt     = err_rec_r;
      resp_t.start    = 1'b0;
      resp_t.stop     = 1'b0;
      off_t.start     = 1'b0;
      off_t.stop      = 1'b0;
      act_t.start     = 1'b0;
      act_t.stop      = 1'b0;
      dpm_eval_req      = 1'b0;
      dpm_sink_off_req  = 1'b0;
      dpm_pullup_req    = 1'b0;
      dpm_source_on_req = 1'b0;
      if (entry_r) begin
         case (state_r)
            PRS_SNK_JUDGE:      dpm_eval_req = 1'b1;
            PRS_SNK_AGREE: begin
               tx_req_nxt = 1'b1;
               tx_msg_nxt = `PRS_MSG_ACCEPT;
            end
            // start off timer and request sink off in the same cycle
            PRS_SNK_POWER_DOWN: begin
               off_t.start      = 1'b1;
               dpm_sink_off_req = 1'b1;
            end
            PRS_SUPPLY_ENABLE: begin
               dpm_source_on_req = 1'b1;
               act_t.start       = 1'b1;
            end
            PRS_SNK_REFUSE, PRS_SRC_REFUSE: begin
               tx_req_nxt = 1'b1;
               tx_msg_nxt = refuse_wait_r ? `PRS_MSG_WAIT : `PRS_MSG_REJECT;
            end
            PRS_SNK_REQUEST, PRS_SRC_REQUEST: begin
               tx_req_nxt   = 1'b1;
               tx_msg_nxt   = `PRS_MSG_PR_SWAP;
               resp_t.start = 1'b1;
            end
            PRS_FETCH_CAPS: begin
               tx_req_nxt   = 1'b1;
               tx_msg_nxt   = `PRS_MSG_GET_SRC_CAP;
               resp_t.start = 1'b1;
            end
            default: ;
         endcase
      end
      if (state_r == PRS_PULLUP_ASSERT) dpm_pullup_req = 1'b1;

      case (state_r)
         PRS_SINK_READY: begin
            if (got(rx_valid, rx_msg, `PRS_MSG_PR_SWAP)) state_nxt = PRS_SNK_JUDGE;
            else if (dpm_swap_required)                  state_nxt = PRS_SNK_REQUEST;
         end
         PRS_SOURCE_READY: begin
            if (got(rx_valid, rx_msg, `PRS_MSG_PR_SWAP)) state_nxt = PRS_SRC_REFUSE;
            else if (dpm_swap_required)                  state_nxt = PRS_SRC_REQUEST;
            else if (dpm_get_caps)                       state_nxt = PRS_FETCH_CAPS;
         end
         PRS_SNK_JUDGE: if (dpm_eval_valid) begin
            refuse_wait_nxt = dpm_eval_wait;
            state_nxt       = dpm_eval_ok ? PRS_SNK_AGREE : PRS_SNK_REFUSE;
         end
         PRS_SNK_AGREE: if (tx_sent) state_nxt = PRS_SNK_POWER_DOWN;
         PRS_SNK_POWER_DOWN: begin
            if (off_t.expired) begin
               if (toggling_dual_role_port) err_rec_nxt = 1'b1;
               state_nxt = fail_target(toggling_dual_role_port, device_type);
            end else if (got(rx_valid, rx_msg, `PRS_MSG_PS_RDY)) begin
               off_t.stop = 1'b1;
               state_nxt  = toggling_dual_role_port ? PRS_PULLUP_ASSERT : PRS_SUPPLY_ENABLE;
            end
         end
         PRS_PULLUP_ASSERT: if (dpm_pullup_done) state_nxt = PRS_SUPPLY_ENABLE;
         PRS_SUPPLY_ENABLE: begin
            // send PS_RDY once supply is on
            if (dpm_source_on && !tx_req_r && tx_msg_r != `PRS_MSG_PS_RDY) begin
               tx_req_nxt = 1'b1;
               tx_msg_nxt = `PRS_MSG_PS_RDY;
            end else if (tx_msg_r == `PRS_MSG_PS_RDY && tx_sent) begin
               state_nxt = PRS_SOURCE_STARTUP;
            // PS_RDY not acknowledged, no soft reset
            end else if (tx_msg_r == `PRS_MSG_PS_RDY && tx_failed) begin
               if (toggling_dual_role_port) err_rec_nxt = 1'b1;
               state_nxt = fail_target(toggling_dual_role_port, device_type);
            end
         end
         PRS_SOURCE_STARTUP: state_nxt = PRS_SOURCE_READY;
         // back to ready of present role
         PRS_SNK_REFUSE: if (tx_sent) state_nxt = PRS_SINK_READY;
         PRS_SRC_REFUSE: if (tx_sent) state_nxt = PRS_SOURCE_READY;
         PRS_SNK_REQUEST: begin
            if (rx_reject || rx_wait || resp_t.expired) state_nxt = PRS_SINK_READY;
            else if (rx_accept)                         state_nxt = PRS_SNK_POWER_DOWN;
         end
         PRS_SRC_REQUEST: begin
            if (rx_reject || rx_wait || resp_t.expired) state_nxt = PRS_SOURCE_READY;
            else if (rx_accept)                         state_nxt = PRS_SRC_POWER_DOWN;
         end
         PRS_SRC_POWER_DOWN: ;
         PRS_FETCH_CAPS: begin
            if (got(rx_valid, rx_msg, `PRS_MSG_SRC_CAPS) || rx_reject) begin
               caps_done_nxt = 1'b1;
               state_nxt     = PRS_SOURCE_READY;
            end else if (resp_t.expired) begin
               caps_to_nxt = 1'b1;
               state_nxt   = PRS_SOURCE_READY;
            end
         end
         PRS_SRC_HARD_RESET: state_nxt = PRS_SOURCE_READY;
         PRS_SNK_HARD_RESET: state_nxt = PRS_SINK_READY;
         default: state_nxt = PRS_SINK_READY;
      endcase

      // hard reset returns to default operation
      if (hard_reset) begin
         state_nxt = start_as_source ? PRS_SRC_HARD_RESET : PRS_SNK_HARD_RESET;
         tx_req_nxt = 1'b0;
      end

      // stop response timer when leaving a request state
      if ((state_r == PRS_SRC_REQUEST || state_r == PRS_SNK_REQUEST ||
           state_r == PRS_FETCH_CAPS) && state_nxt != state_r)
         resp_t.stop = 1'b1;
      if (state_r == PRS_SUPPLY_ENABLE && state_nxt != state_r) act_t.stop = 1'b1;
      if (state_nxt != state_r) entry_nxt = 1'b1;
      if (state_nxt == PRS_SINK_READY || state_nxt == PRS_SOURCE_READY)
         err_rec_nxt = 1'b0;
      if (state_nxt == PRS_SINK_READY || state_nxt == PRS_SOURCE_READY)
         tx_msg_nxt = `PRS_MSG_NONE;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_r       <= PRS_SINK_READY;
         entry_r       <= 1'b0;
         refuse_wait_r <= 1'b0;
         tx_req_r      <= 1'b0;
         tx_msg_r      <= `PRS_MSG_NONE;
         caps_done_r   <= 1'b0;
         caps_to_r     <= 1'b0;
         err_rec_r     <= 1'b0;
      end else if (ce) begin
         state_r       <= state_nxt;
         entry_r       <= entry_nxt;
         refuse_wait_r <= refuse_wait_nxt;
         tx_req_r      <= tx_req_nxt;
         tx_msg_r      <= tx_msg_nxt;
         caps_done_r   <= caps_done_nxt;
         caps_to_r     <= caps_to_nxt;
         err_rec_r     <= err_rec_nxt;
      end
   end

   assign tx_req               = tx_req_r;
   assign tx_msg               = tx_msg_r;
   assign dpm_caps_done        = caps_done_r;
   assign dpm_caps_timeout     = caps_to_r;
   assign error_recovery_state = err_rec_r;
   assign state_out            = state_r;
   assign act_timer_expired    = act_t.expired;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_judge_query: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SINK_READY && got(rx_valid, rx_msg, `PRS_MSG_PR_SWAP)
       && !hard_reset) ##1 ce |-> dpm_eval_req) else $error("no evaluation query");
   a_snk_req_tx: assert property (@(posedge clk) disable iff (!resetn)
      (ce && entry_r && state_r == PRS_SNK_REQUEST && !hard_reset) |=>
      (tx_req && tx_msg == `PRS_MSG_PR_SWAP)) else $error("PR_Swap not sent");
   a_src_req_exit: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SRC_REQUEST && rx_reject && !hard_reset) |=>
      state_r == PRS_SOURCE_READY) else $error("reject not honoured");
   a_snk_req_exit: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SNK_REQUEST && rx_accept && !resp_t.expired && !hard_reset) |=>
      state_r == PRS_SNK_POWER_DOWN) else $error("accept not honoured");
   a_refuse_ret: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SNK_REFUSE && tx_sent && !hard_reset) |=>
      state_r == PRS_SINK_READY) else $error("refuse did not return");
   a_psrdy_toggle: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SNK_POWER_DOWN && !off_t.expired && toggling_dual_role_port
       && got(rx_valid, rx_msg, `PRS_MSG_PS_RDY) && !hard_reset) |=>
      state_r == PRS_PULLUP_ASSERT) else $error("pull-up step skipped");
   a_off_exp_toggle: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SNK_POWER_DOWN && off_t.expired && toggling_dual_role_port
       && !hard_reset) |=> error_recovery_state) else $error("no error recovery");
   a_hr_resets: assert property (@(posedge clk) disable iff (!resetn)
      (ce && hard_reset && !start_as_source) |=> state_r == PRS_SNK_HARD_RESET)
      else $error("hard reset ignored");
   a_resp_stop_exit: assert property (@(posedge clk) disable iff (!resetn)
      (ce && state_r == PRS_SRC_REQUEST && state_nxt != PRS_SRC_REQUEST) |=>
      !u_resp.run_r) else $error("response timer left running");
endmodule : prs_policy_engine
`default_nettype wire

// [tb/prs_partner_model.sv]
// Remote port partner and protocol layer model for the swap engine
`timescale 1ns/1ns
`default_nettype none
`include "prs_defs.svh"
module prs_partner_model (
   input  wire logic                  clk,
   input  wire logic                  tx_req,
   input  wire logic [`PRS_MSG_W-1:0] tx_msg,
   output logic                       tx_sent,
   output logic                       tx_failed,
   output logic                       rx_valid,
   output logic [`PRS_MSG_W-1:0]      rx_msg
);
   logic [`PRS_MSG_W-1:0] last_msg, reply_msg, fail_msg;
   int                    ack_dly;

   initial begin
      {tx_sent, tx_failed, rx_valid} = 3'h0;
      {rx_msg, last_msg, reply_msg, fail_msg} = 12'h000;
      ack_dly = 2;
   end

   // Code is inverted after the strobe so a stale value never looks valid
   task automatic send(input logic [`PRS_MSG_W-1:0] m);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_msg   = m;
      @(negedge clk);
      rx_valid = 1'b0;
      rx_msg   = ~m;
   endtask : send

   task automatic answer(input logic [`PRS_MSG_W-1:0] m);
      repeat (ack_dly) @(negedge clk);
      tx_failed = (m === fail_msg);
      tx_sent   = (m !== fail_msg);
      @(negedge clk);
      {tx_sent, tx_failed} = 2'h0;
      if (m !== fail_msg && reply_msg !== `PRS_MSG_NONE &&
          (m === `PRS_MSG_PR_SWAP || m === `PRS_MSG_GET_SRC_CAP)) begin
         send(reply_msg);
      end
   endtask : answer

   always @(posedge clk) begin
      if (tx_req === 1'b1) begin
         last_msg <= tx_msg;
         fork
            answer(tx_msg);
         join_none
      end
   end
endmodule : prs_partner_model
`default_nettype wire

// [tb/tb_power_role_swap_policy.sv]
// Self-checking bench for the power role swap policy engine
`timescale 1ns/1ns
`default_nettype none
`include "prs_defs.svh"
module tb_power_role_swap_policy;
   import prs_pkg::*;
   localparam logic [`PRS_TMR_W-1:0] TCYC = 20'h00010;
   logic                  clk, resetn, ce, start_as_source, toggling_dual_role_port;
   logic [1:0]            device_type;
   logic                  hard_reset, dpm_swap_required, dpm_get_caps, dpm_eval_valid;
   logic                  dpm_eval_ok, dpm_eval_wait, dpm_pullup_done, dpm_source_on;
   logic                  dpm_eval_req, dpm_sink_off_req, dpm_pullup_req, dpm_source_on_req;
   logic                  dpm_caps_done, dpm_caps_timeout, error_recovery_state;
   logic [3:0]            state_out;
   logic                  rx_valid, tx_req, tx_sent, tx_failed, act_timer_expired;
   logic [`PRS_MSG_W-1:0] rx_msg, tx_msg;
   int                    miscompares, cmp_count;
   int                    cnt [6];

   prs_policy_engine #(.SENDER_RESP_CYC(TCYC), .SRC_OFF_CYC(TCYC), .SRC_ACT_CYC(TCYC)) dut (
      .clk, .resetn, .ce, .start_as_source, .toggling_dual_role_port, .device_type,
      .hard_reset, .dpm_swap_required, .dpm_get_caps, .dpm_eval_valid, .dpm_eval_ok,
      .dpm_eval_wait, .dpm_pullup_done, .dpm_source_on, .dpm_eval_req, .dpm_sink_off_req,
      .dpm_pullup_req, .dpm_source_on_req, .dpm_caps_done, .dpm_caps_timeout,
      .error_recovery_state, .state_out, .rx_valid, .rx_msg, .tx_req, .tx_msg, .tx_sent,
      .tx_failed, .act_timer_expired);

   prs_partner_model pm (.clk, .tx_req, .tx_msg, .tx_sent, .tx_failed, .rx_valid, .rx_msg);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulse counters, sampled where the engine samples
   always @(posedge clk) begin
      if (dpm_eval_req === 1'b1) cnt[0]++;
      if (dpm_sink_off_req === 1'b1) cnt[1]++;
      if (dpm_source_on_req === 1'b1) cnt[2]++;
      if (dpm_caps_done === 1'b1) cnt[3]++;
      if (dpm_caps_timeout === 1'b1) cnt[4]++;
      if (act_timer_expired === 1'b1) cnt[5]++;
   end

   task automatic close_out();
      if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Bounded poll at falling edges; a miss ends the run
   task automatic wait_st(input logic [3:0] s);
      for (int i = 0; i < 200 && state_out !== s; i++) @(negedge clk);
      chk("state_out", s, state_out);
      if (state_out !== s) close_out();
   endtask : wait_st

   function automatic void idle();
      {dpm_swap_required, dpm_get_caps, dpm_eval_valid, dpm_eval_ok} = 4'h0;
      {dpm_eval_wait, dpm_pullup_done, dpm_source_on, hard_reset} = 4'h0;
      {start_as_source, toggling_dual_role_port, device_type} = 4'h0;
      pm.reply_msg = `PRS_MSG_NONE;
      pm.fail_msg  = `PRS_MSG_NONE;
   endfunction : idle

   task automatic rst();
      @(negedge clk);
      resetn = 1'b0;
      idle();
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      cnt = '{default: 0};
   endtask : rst

   task automatic judge(input logic ok, input logic wt);
      pm.send(`PRS_MSG_PR_SWAP);
      wait_st(PRS_SNK_JUDGE);
      {dpm_eval_valid, dpm_eval_ok, dpm_eval_wait} = {1'b1, ok, wt};
      @(negedge clk);
      {dpm_eval_valid, dpm_eval_ok, dpm_eval_wait} = 3'h0;
   endtask : judge

   task automatic accept_path(input logic tog, input logic [1:0] dt,
                              input logic [2:0] fmsg, input logic [3:0] fin);
      rst();
      toggling_dual_role_port = tog;
      device_type = dt;
      judge(1'b1, 1'b0);
      wait_st(PRS_SNK_AGREE);
      wait_st(PRS_SNK_POWER_DOWN);
      chk("accept_msg", 4'(`PRS_MSG_ACCEPT), 4'(pm.last_msg));
      pm.send(`PRS_MSG_PS_RDY);
      if (tog) begin
         wait_st(PRS_PULLUP_ASSERT);
         chk("pullup_req", 4'h1, 4'(dpm_pullup_req));
         dpm_pullup_done = 1'b1;
      end
      wait_st(PRS_SUPPLY_ENABLE);
      // Toggling runs hold the supply off until the activity timer runs out
      if (tog) repeat (20) @(negedge clk);
      pm.fail_msg = fmsg;
      dpm_source_on = 1'b1;
      wait_st(fin);
      chk("err_recovery", 4'(tog & (fmsg != 3'h0)), 4'(error_recovery_state));
      repeat (4) @(negedge clk);
      chk("ps_rdy_msg", 4'(`PRS_MSG_PS_RDY), 4'(pm.last_msg));
      chk("eval_req", 4'h1, 4'(cnt[0]));
      chk("sink_off_req", 4'h1, 4'(cnt[1]));
      chk("source_on_req", 4'h1, 4'(cnt[2]));
      chk("act_expired", 4'(tog), 4'(cnt[5]));
   endtask : accept_path

   task automatic refuse(input logic wt);
      rst();
      pm.ack_dly = wt ? 6 : 2;
      judge(1'b0, wt);
      wait_st(PRS_SNK_REFUSE);
      wait_st(PRS_SINK_READY);
      chk("refuse_msg", wt ? 4'(`PRS_MSG_WAIT) : 4'(`PRS_MSG_REJECT), 4'(pm.last_msg));
      pm.ack_dly = 2;
      judge(1'b0, 1'b0);
      wait_st(PRS_SNK_REFUSE);
   endtask : refuse

   task automatic snk_req(input logic [2:0] rep, input logic tog, input logic [1:0] dt,
                          input logic [3:0] fin);
      rst();
      toggling_dual_role_port = tog;
      device_type = dt;
      pm.reply_msg = rep;
      dpm_swap_required = 1'b1;
      wait_st(PRS_SNK_REQUEST);
      dpm_swap_required = 1'b0;
      if (rep === `PRS_MSG_NONE) begin
         ce = 1'b0;
         repeat (20) @(negedge clk);
         chk("frozen_state", PRS_SNK_REQUEST, state_out);
         ce = 1'b1;
      end
      if (rep === `PRS_MSG_ACCEPT) wait_st(PRS_SNK_POWER_DOWN);
      wait_st(fin);
      chk("swap_msg", 4'(`PRS_MSG_PR_SWAP), 4'(pm.last_msg));
      chk("err_recovery", 4'(tog), 4'(error_recovery_state));
   endtask : snk_req

   task automatic src_scn(input logic act, input logic [2:0] rep, input logic [3:0] fin);
      rst();
      start_as_source = 1'b1;
      hard_reset = 1'b1;
      @(negedge clk);
      hard_reset = 1'b0;
      wait_st(PRS_SOURCE_READY);
      pm.reply_msg = rep;
      {dpm_get_caps, dpm_swap_required} = {act, !act};
      wait_st(act ? PRS_FETCH_CAPS : PRS_SRC_REQUEST);
      {dpm_get_caps, dpm_swap_required} = 2'h0;
      wait_st(fin);
      chk("resp_timer_run", 4'h0, 4'(dut.u_resp.run_r));
      chk("src_msg", act ? 4'(`PRS_MSG_GET_SRC_CAP) : 4'(`PRS_MSG_PR_SWAP),
          4'(pm.last_msg));
      repeat (32) @(negedge clk);
      chk("state_out", fin, state_out);
      chk("caps_done", 4'(act && rep == `PRS_MSG_SRC_CAPS), 4'(cnt[3]));
      chk("caps_timeout", 4'(act && rep == `PRS_MSG_NONE), 4'(cnt[4]));
   endtask : src_scn

   task automatic hr_snk();
      rst();
      dpm_swap_required = 1'b1;
      wait_st(PRS_SNK_REQUEST);
      {dpm_swap_required, hard_reset} = 2'h1;
      @(negedge clk);
      hard_reset = 1'b0;
      chk("state_out", PRS_SNK_HARD_RESET, state_out);
      chk("tx_req", 4'h0, 4'(tx_req));
      wait_st(PRS_SINK_READY);
   endtask : hr_snk

   task automatic src_refuse();
      rst();
      {start_as_source, hard_reset} = 2'h3;
      @(negedge clk);
      hard_reset = 1'b0;
      wait_st(PRS_SOURCE_READY);
      pm.send(`PRS_MSG_PR_SWAP);
      wait_st(PRS_SRC_REFUSE);
      wait_st(PRS_SOURCE_READY);
      chk("refuse_msg", 4'(`PRS_MSG_REJECT), 4'(pm.last_msg));
   endtask : src_refuse

   initial begin
      miscompares = 0;
      cmp_count = 0;
      cnt = '{default: 0};
      ce = 1'b1;
      resetn = 1'b0;
      idle();
      repeat (12) @(negedge clk);
      chk("state_out", PRS_SINK_READY, state_out);
      chk("tx_req", 4'h0, 4'(tx_req));
      resetn = 1'b1;
      accept_path(1'b0, 2'h0, `PRS_MSG_NONE, PRS_SOURCE_STARTUP);
      accept_path(1'b1, 2'h0, `PRS_MSG_NONE, PRS_SOURCE_STARTUP);
      accept_path(1'b0, 2'h1, `PRS_MSG_PS_RDY, PRS_SRC_HARD_RESET);
      accept_path(1'b0, 2'h2, `PRS_MSG_PS_RDY, PRS_SNK_HARD_RESET);
      accept_path(1'b1, 2'h0, `PRS_MSG_PS_RDY, PRS_SNK_HARD_RESET);
      refuse(1'b0);
      refuse(1'b1);
      snk_req(`PRS_MSG_REJECT, 1'b0, 2'h0, PRS_SINK_READY);
      snk_req(`PRS_MSG_WAIT, 1'b0, 2'h0, PRS_SINK_READY);
      snk_req(`PRS_MSG_NONE, 1'b0, 2'h0, PRS_SINK_READY);
      snk_req(`PRS_MSG_ACCEPT, 1'b0, 2'h0, PRS_SRC_HARD_RESET);
      snk_req(`PRS_MSG_ACCEPT, 1'b0, 2'h1, PRS_SRC_HARD_RESET);
      snk_req(`PRS_MSG_ACCEPT, 1'b0, 2'h2, PRS_SNK_HARD_RESET);
      snk_req(`PRS_MSG_ACCEPT, 1'b1, 2'h0, PRS_SNK_HARD_RESET);
      src_scn(1'b0, `PRS_MSG_REJECT, PRS_SOURCE_READY);
      src_scn(1'b0, `PRS_MSG_WAIT, PRS_SOURCE_READY);
      src_scn(1'b0, `PRS_MSG_NONE, PRS_SOURCE_READY);
      src_scn(1'b0, `PRS_MSG_ACCEPT, PRS_SRC_POWER_DOWN);
      src_scn(1'b1, `PRS_MSG_SRC_CAPS, PRS_SOURCE_READY);
      src_scn(1'b1, `PRS_MSG_NONE, PRS_SOURCE_READY);
      hr_snk();
      src_refuse();
      close_out();
   end
endmodule : tb_power_role_swap_policy
`default_nettype wire
